// ===== pkg/fileop_pkg.sv
// constants and types for the file-register unary ops and jump unit
package fileop_pkg;

   // ---------------------------------------------------------------
   // widths
   // ---------------------------------------------------------------
   localparam int DATA_W   = 8;
   localparam int INSTR_W  = 14;
   localparam int FADDR_W  = 7;
   localparam int PC_W     = 13;
   localparam int LIT_W    = 11;

   // ---------------------------------------------------------------
   // field positions
   // ---------------------------------------------------------------
   localparam int OPC_HI       = 13;
   localparam int OPC_LO       = 8;
   localparam int DEST_BIT     = 7;
   localparam int JMP_OPC_HI   = 13;
   localparam int JMP_OPC_LO   = 11;
   localparam int LATCH_PC_HI  = 4;
   localparam int LATCH_PC_LO  = 3;

   // ---------------------------------------------------------------
   // opcodes (upper six bits; jump uses upper three)
   // ---------------------------------------------------------------
   localparam logic [5:0] OPC_COMPLEMENT = 6'h09;
   localparam logic [5:0] OPC_DECREMENT  = 6'h03;
   localparam logic [5:0] OPC_INCREMENT  = 6'h0a;
   localparam logic [5:0] OPC_DEC_SKIP   = 6'h0b;
   localparam logic [5:0] OPC_INC_SKIP   = 6'h0f;
   localparam logic [2:0] OPC_JUMP       = 3'h5;

   // ---------------------------------------------------------------
   // reset values and counts
   // ---------------------------------------------------------------
   localparam logic [PC_W-1:0]   PC_RESET   = 13'h0000;
   localparam logic [DATA_W-1:0] W_RESET    = 8'h00;
   localparam logic              Z_RESET    = 1'b0;
   localparam int                FLUSH_CYC  = 1;

   typedef enum logic [1:0]
   {
      ST_EXEC  = 2'b01,
      ST_FLUSH = 2'b10
   } exec_state_t;

   typedef enum logic [2:0]
   {
      OP_NONE,
      OP_COMPLEMENT,
      OP_DECREMENT,
      OP_INCREMENT,
      OP_DEC_SKIP,
      OP_INC_SKIP,
      OP_JUMP
   } op_kind_t;

endpackage

// ===== rtl/fileop_decode.sv
// instruction word decoder: op kind, file address, destination, literal
`timescale 1ns/1ps
module fileop_decode
(
   input  wire logic [fileop_pkg::INSTR_W-1:0] instr_i,
   output fileop_pkg::op_kind_t                 kind_o,
   output logic [fileop_pkg::FADDR_W-1:0]       faddr_o,
   output logic                                 dest_o,
   output logic [fileop_pkg::LIT_W-1:0]         lit_o
);

   logic [5:0] opc;

   always_comb
   begin
      opc     = instr_i[fileop_pkg::OPC_HI:fileop_pkg::OPC_LO];
      faddr_o = instr_i[fileop_pkg::FADDR_W-1:0];
      dest_o  = instr_i[fileop_pkg::DEST_BIT];
      lit_o   = instr_i[fileop_pkg::LIT_W-1:0];
      kind_o  = fileop_pkg::OP_NONE;
      if (instr_i[fileop_pkg::JMP_OPC_HI:fileop_pkg::JMP_OPC_LO] == fileop_pkg::OPC_JUMP)
      begin
         kind_o = fileop_pkg::OP_JUMP;
      end
      else if (opc == fileop_pkg::OPC_COMPLEMENT)
      begin
         kind_o = fileop_pkg::OP_COMPLEMENT;
      end
      else if (opc == fileop_pkg::OPC_DECREMENT)
      begin
         kind_o = fileop_pkg::OP_DECREMENT;
      end
      else if (opc == fileop_pkg::OPC_INCREMENT)
      begin
         kind_o = fileop_pkg::OP_INCREMENT;
      end
      else if (opc == fileop_pkg::OPC_DEC_SKIP)
      begin
         kind_o = fileop_pkg::OP_DEC_SKIP;
      end
      else if (opc == fileop_pkg::OPC_INC_SKIP)
      begin
         kind_o = fileop_pkg::OP_INC_SKIP;
      end
   end

endmodule

// ===== rtl/fileop_unit.sv
// execution unit for file-register unary ops and the unconditional jump
//
// Function
// - complement inverts every file register bit, goes to the chosen destination, sets Z.
// - destination bit 0 writes the accumulator, 1 writes back to the file register.
// - the jump loads its 11-bit literal into program counter bits 10..0.
// - the jump takes PC bits 12..11 from high latch bits 4..3 and changes no flag.
// - the jump takes two instruction cycles.
// - decrement subtracts one, goes to the chosen destination and updates Z.
// - increment adds one, goes to the chosen destination and updates Z.
// - decrement-and-skip writes its result, leaves flags, and on zero runs a no-op next.
// - increment-and-skip writes its result, leaves flags, and on zero runs a no-op next.
// - a nonzero skip-variant result lets the next instruction run with no added cycle.
// - the flag touched by the non-skip ops is Z, set when the result is zero.
`timescale 1ns/1ps
module fileop_unit
(
   input  wire logic                               CLK_I,
   input  wire logic                               SRST_I,
   input  wire logic                               INSTR_VALID_I,
   input  wire logic [fileop_pkg::INSTR_W-1:0]     INSTR_I,
   input  wire logic [fileop_pkg::DATA_W-1:0]      FILE_RDATA_I,
   input  wire logic [fileop_pkg::DATA_W-1:0]      PC_HIGH_LATCH_I,
   output logic                                    INSTR_READY_O,
   output logic [fileop_pkg::FADDR_W-1:0]          FILE_ADDR_O,
   output logic                                    FILE_WE_O,
   output logic [fileop_pkg::DATA_W-1:0]           FILE_WDATA_O,
   output logic [fileop_pkg::DATA_W-1:0]           W_O,
   output logic                                    ZERO_FLAG_O,
   output logic [fileop_pkg::PC_W-1:0]             PC_O,
   output logic                                    RETIRE_O,
   output logic                                    FLUSH_O
);

   // ---------------------------------------------------------------
   // decode
   // ---------------------------------------------------------------
   fileop_pkg::op_kind_t                 kind;
   logic [fileop_pkg::FADDR_W-1:0]       faddr;
   logic                                 dest;
   logic [fileop_pkg::LIT_W-1:0]         lit;

   fileop_decode u_decode
   (
      .instr_i (INSTR_I),
      .kind_o  (kind),
      .faddr_o (faddr),
      .dest_o  (dest),
      .lit_o   (lit)
   );

   // ---------------------------------------------------------------
   // state
   // ---------------------------------------------------------------
   fileop_pkg::exec_state_t              state_reg;
   fileop_pkg::exec_state_t              state_next;
   logic [fileop_pkg::DATA_W-1:0]        w_reg;
   logic [fileop_pkg::DATA_W-1:0]        w_next;
   logic                                 z_reg;
   logic                                 z_next;
   logic [fileop_pkg::PC_W-1:0]          pc_reg;
   logic [fileop_pkg::PC_W-1:0]          pc_next;
   logic                                 fwe_reg;
   logic                                 fwe_next;
   logic [fileop_pkg::DATA_W-1:0]        fwd_reg;
   logic [fileop_pkg::DATA_W-1:0]        fwd_next;
   logic                                 retire_reg;
   logic                                 retire_next;
   logic                                 flush_reg;
   logic                                 flush_next;

   logic [fileop_pkg::DATA_W-1:0]        result;
   logic                                 take;
   logic                                 is_zero;

   function automatic logic [fileop_pkg::PC_W-1:0] pc_step
   (
      input logic [fileop_pkg::PC_W-1:0] pc
   );
      pc_step = pc + 13'h0001;
   endfunction

   // ---------------------------------------------------------------
   // next-state logic
   // ---------------------------------------------------------------
   always_comb
   begin
      state_next  = state_reg;
      w_next      = w_reg;
      z_next      = z_reg;
      pc_next     = pc_reg;
      fwe_next    = 1'b0;
      fwd_next    = fwd_reg;
      retire_next = 1'b0;
      flush_next  = 1'b0;
      take        = INSTR_VALID_I && (state_reg == fileop_pkg::ST_EXEC);
      unique case (kind)
         fileop_pkg::OP_COMPLEMENT: result = ~FILE_RDATA_I;
         fileop_pkg::OP_DECREMENT,
         fileop_pkg::OP_DEC_SKIP:   result = FILE_RDATA_I - 8'h01;
         fileop_pkg::OP_INCREMENT,
         fileop_pkg::OP_INC_SKIP:   result = FILE_RDATA_I + 8'h01;
         default:                   result = FILE_RDATA_I;
      endcase
      is_zero = (result == 8'h00);
      unique case (state_reg)
         fileop_pkg::ST_EXEC:
         begin
            if (take)
            begin
               retire_next = 1'b1;
               pc_next     = pc_step(pc_reg);
               unique case (kind)
                  fileop_pkg::OP_COMPLEMENT,
                  fileop_pkg::OP_DECREMENT,
                  fileop_pkg::OP_INCREMENT:
                  begin
                     z_next = is_zero;
                     if (dest)
                     begin
                        fwe_next = 1'b1;
                        fwd_next = result;
                     end
                     else
                     begin
                        w_next = result;
                     end
                  end
                  fileop_pkg::OP_DEC_SKIP,
                  fileop_pkg::OP_INC_SKIP:
                  begin
                     // flags untouched by the skip variants
                     if (dest)
                     begin
                        fwe_next = 1'b1;
                        fwd_next = result;
                     end
                     else
                     begin
                        w_next = result;
                     end
                     if (is_zero)
                     begin
                        state_next = fileop_pkg::ST_FLUSH;
                        flush_next = 1'b1;
                     end
                  end
                  fileop_pkg::OP_JUMP:
                  begin
                     pc_next    = {PC_HIGH_LATCH_I[fileop_pkg::LATCH_PC_HI:
                                                   fileop_pkg::LATCH_PC_LO],
                                   lit};
                     state_next = fileop_pkg::ST_FLUSH;
                     flush_next = 1'b1;
                  end
                  default:
                  begin
                     retire_next = 1'b1;
                  end
               endcase
            end
         end
         fileop_pkg::ST_FLUSH:
         begin
            // the fetched word is dropped: one no_operation cycle
            state_next = fileop_pkg::ST_EXEC;
            if (INSTR_VALID_I)
            begin
               pc_next = pc_step(pc_reg);
            end
         end
         default:
         begin
            state_next = fileop_pkg::ST_EXEC;
         end
      endcase
   end

   // ---------------------------------------------------------------
   // registers
   // ---------------------------------------------------------------
   always_ff @(posedge CLK_I)
   begin
      if (SRST_I)
      begin
         state_reg  <= fileop_pkg::ST_EXEC;
         w_reg      <= fileop_pkg::W_RESET;
         z_reg      <= fileop_pkg::Z_RESET;
         pc_reg     <= fileop_pkg::PC_RESET;
         fwe_reg    <= 1'b0;
         fwd_reg    <= 8'h00;
         retire_reg <= 1'b0;
         flush_reg  <= 1'b0;
      end
      else
      begin
         state_reg  <= state_next;
         w_reg      <= w_next;
         z_reg      <= z_next;
         pc_reg     <= pc_next;
         fwe_reg    <= fwe_next;
         fwd_reg    <= fwd_next;
         retire_reg <= retire_next;
         flush_reg  <= flush_next;
      end
   end

   // ---------------------------------------------------------------
   // outputs
   // ---------------------------------------------------------------
   // file address follows the incoming word so the read data is same-cycle
   assign FILE_ADDR_O   = faddr;
   assign INSTR_READY_O = 1'b1;
   assign FILE_WE_O     = fwe_reg;
   assign FILE_WDATA_O  = fwd_reg;
   assign W_O           = w_reg;
   assign ZERO_FLAG_O   = z_reg;
   assign PC_O          = pc_reg;
   assign RETIRE_O      = retire_reg;
   assign FLUSH_O       = flush_reg;

endmodule

// ===== bench/fileop_unit_sva.sv
// assertions on the ports of the file-register unary ops and jump unit
`timescale 1ns/1ps
module fileop_unit_chk
(
   input wire logic        CLK_I,
   input wire logic        SRST_I,
   input wire logic        INSTR_VALID_I,
   input wire logic [13:0] INSTR_I,
   input wire logic [7:0]  FILE_RDATA_I,
   input wire logic [7:0]  PC_HIGH_LATCH_I,
   input wire logic        INSTR_READY_O,
   input wire logic [6:0]  FILE_ADDR_O,
   input wire logic        FILE_WE_O,
   input wire logic [7:0]  FILE_WDATA_O,
   input wire logic [7:0]  W_O,
   input wire logic        ZERO_FLAG_O,
   input wire logic [12:0] PC_O,
   input wire logic        RETIRE_O,
   input wire logic        FLUSH_O
);
   logic        acc;
   logic        jmp;
   logic [5:0]  op;
   logic [7:0]  fd_q;
   logic [7:0]  lat_q;
   logic [13:0] ins_q;
   // the dropped cycle is exactly the one in which the flush pulse shows
   assign acc = INSTR_VALID_I && !FLUSH_O;
   assign jmp = INSTR_I[13:11] == fileop_pkg::OPC_JUMP;
   assign op  = INSTR_I[13:8];
   always_ff @(posedge CLK_I)
   begin
      fd_q  <= FILE_RDATA_I;
      lat_q <= PC_HIGH_LATCH_I;
      ins_q <= INSTR_I;
   end
   default clocking @(posedge CLK_I); endclocking
   default disable iff (SRST_I);
   property p_addr; FILE_ADDR_O == INSTR_I[6:0]; endproperty
   a_addr: assert property (p_addr) else $error("file address wrong");
   property p_jpc; acc && jmp |=> PC_O == {lat_q[4:3], ins_q[10:0]}; endproperty
   a_jpc: assert property (p_jpc) else $error("jump target wrong");
   property p_jcyc; acc && jmp |=> FLUSH_O && RETIRE_O ##1 !RETIRE_O && !FILE_WE_O; endproperty
   a_jcyc: assert property (p_jcyc) else $error("jump not two cycles");
   property p_jz; acc && jmp |=> ZERO_FLAG_O == $past(ZERO_FLAG_O); endproperty
   a_jz: assert property (p_jz) else $error("jump changed zero flag");
   property p_inc; acc && op == fileop_pkg::OPC_INCREMENT && INSTR_I[7] |=> FILE_WE_O
      && FILE_WDATA_O == fd_q + 8'h01 && ZERO_FLAG_O == (fd_q == 8'hff); endproperty
   a_inc: assert property (p_inc) else $error("increment wrong");
   property p_dec; acc && op == fileop_pkg::OPC_DECREMENT |=> ZERO_FLAG_O == (fd_q == 8'h01);
   endproperty
   a_dec: assert property (p_dec) else $error("decrement zero flag wrong");
   property p_com; acc && op == fileop_pkg::OPC_COMPLEMENT && !INSTR_I[7] |=> W_O == ~fd_q
      && !FILE_WE_O && ZERO_FLAG_O == (fd_q == 8'hff); endproperty
   a_com: assert property (p_com) else $error("complement wrong");
   property p_dsz; acc && op == fileop_pkg::OPC_DEC_SKIP && FILE_RDATA_I == 8'h01
      |=> FLUSH_O && $stable(ZERO_FLAG_O) ##1 !RETIRE_O; endproperty
   a_dsz: assert property (p_dsz) else $error("decrement skip wrong");
   property p_isz; acc && op == fileop_pkg::OPC_INC_SKIP
      |=> $stable(ZERO_FLAG_O) && FLUSH_O == (fd_q == 8'hff); endproperty
   a_isz: assert property (p_isz) else $error("increment skip wrong");
endmodule
bind fileop_unit fileop_unit_chk i_chk (.CLK_I(CLK_I), .SRST_I(SRST_I),
   .INSTR_VALID_I(INSTR_VALID_I), .INSTR_I(INSTR_I), .FILE_RDATA_I(FILE_RDATA_I),
   .PC_HIGH_LATCH_I(PC_HIGH_LATCH_I), .INSTR_READY_O(INSTR_READY_O), .FILE_ADDR_O(FILE_ADDR_O),
   .FILE_WE_O(FILE_WE_O), .FILE_WDATA_O(FILE_WDATA_O), .W_O(W_O), .ZERO_FLAG_O(ZERO_FLAG_O),
   .PC_O(PC_O), .RETIRE_O(RETIRE_O), .FLUSH_O(FLUSH_O));

// ===== bench/tb_top.sv
// self-checking bench for the file-register unary ops and jump unit
`timescale 1ns/1ps
module tb_top;
   logic        clk, srst, vld, rdy, we, z, ret, fl, pend, e_we, e_z, e_ret, e_fl;
   logic [13:0] instr;
   logic [7:0]  fdat, lat, wd, w, e_wd, e_w;
   logic [6:0]  fadr;
   logic [12:0] pc, e_pc;
   logic [5:0]  ops [6];
   int          errors, comparisons, k;
   fileop_unit i_dut (.CLK_I(clk), .SRST_I(srst), .INSTR_VALID_I(vld), .INSTR_I(instr),
      .FILE_RDATA_I(fdat), .PC_HIGH_LATCH_I(lat), .INSTR_READY_O(rdy), .FILE_ADDR_O(fadr),
      .FILE_WE_O(we), .FILE_WDATA_O(wd), .W_O(w), .ZERO_FLAG_O(z), .PC_O(pc),
      .RETIRE_O(ret), .FLUSH_O(fl));
   initial
   begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end
   task automatic cmp(input logic [12:0] got, input logic [12:0] exp, input string nm);
      comparisons++;
      if (got !== exp)
      begin
         errors++;
         $display("Error %0t: %s got %h expected %h", $time, nm, got, exp);
      end
   endtask
   // result {known, sets zero, skips, value}
   function automatic logic [10:0] alu(input logic [5:0] op, input logic [7:0] f);
      case (op)
         fileop_pkg::OPC_COMPLEMENT: return {3'b110, ~f};
         fileop_pkg::OPC_DECREMENT:  return {3'b110, f - 8'h01};
         fileop_pkg::OPC_INCREMENT:  return {3'b110, f + 8'h01};
         fileop_pkg::OPC_DEC_SKIP:   return {3'b101, f - 8'h01};
         fileop_pkg::OPC_INC_SKIP:   return {3'b101, f + 8'h01};
         default:                    return 11'h000;
      endcase
   endfunction
   task automatic cmp_all;
      cmp({5'h00, w}, {5'h00, e_w}, "accumulator");
      cmp({12'h000, z}, {12'h000, e_z}, "zero flag");
      cmp(pc, e_pc, "program counter");
      cmp({12'h000, we}, {12'h000, e_we}, "write strobe");
      if (e_we)
         cmp({5'h00, wd}, {5'h00, e_wd}, "write data");
      cmp({12'h000, ret}, {12'h000, e_ret}, "retire");
      cmp({12'h000, fl}, {12'h000, e_fl}, "flush");
   endtask
   task automatic do_reset(input int n);
      srst = 1'b1;
      vld = 1'b0;
      repeat (n) @(negedge clk);
      {e_w, e_z, e_pc, e_we, e_ret, e_fl, pend} = '0;
      cmp_all();
      srst = 1'b0;
   endtask
   task automatic step(input logic v, input logic [13:0] ins, input logic [7:0] f);
      logic [10:0] a;
      vld = v;
      instr = ins;
      fdat = f;
      lat = 8'($urandom);
      a = alu(ins[13:8], f);
      #1;
      cmp({6'h00, fadr}, {6'h00, ins[6:0]}, "file address");
      cmp({12'h000, rdy}, 13'h0001, "ready");
      {e_we, e_ret, e_fl} = 3'b000;
      if (pend)
      begin
         pend = 1'b0;
         e_pc = e_pc + 13'(v);
      end
      else if (v)
      begin
         e_ret = 1'b1;
         e_pc = e_pc + 13'h0001;
         if (ins[13:11] == fileop_pkg::OPC_JUMP)
            {e_pc, e_fl, pend} = {lat[4:3], ins[10:0], 2'b11};
         else if (a[10])
         begin
            if (ins[7])
               {e_we, e_wd} = {1'b1, a[7:0]};
            else
               e_w = a[7:0];
            if (a[9])
               e_z = a[7:0] == 8'h00;
            if (a[8] && a[7:0] == 8'h00)
               {e_fl, pend} = 2'b11;
         end
      end
      @(posedge clk);
      @(negedge clk);
      cmp_all();
   endtask
   task automatic print_verdict;
      $display("comparisons %0d errors %0d", comparisons, errors);
      if (errors == 0 && comparisons > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   initial
   begin
      #50000;
      errors++;
      print_verdict();
   end
   initial
   begin
      {srst, vld, instr, fdat, lat, errors, comparisons} = '0;
      ops = '{fileop_pkg::OPC_COMPLEMENT, fileop_pkg::OPC_DECREMENT, fileop_pkg::OPC_INCREMENT,
              fileop_pkg::OPC_DEC_SKIP, fileop_pkg::OPC_INC_SKIP, 6'h3e};
      void'($urandom(32'h326d));
      do_reset(20);
      step(1'b0, 14'h0000, 8'h00);
      $display("test reset done");
      step(1'b1, {fileop_pkg::OPC_INCREMENT, 8'h85}, 8'hff);
      step(1'b1, {fileop_pkg::OPC_DECREMENT, 8'h11}, 8'h01);
      step(1'b1, {fileop_pkg::OPC_COMPLEMENT, 8'h7f}, 8'h5a);
      step(1'b1, {fileop_pkg::OPC_INC_SKIP, 8'h80}, 8'hff);
      step(1'b1, {fileop_pkg::OPC_INCREMENT, 8'h80}, 8'h10);
      step(1'b1, {fileop_pkg::OPC_DEC_SKIP, 8'h22}, 8'h01);
      step(1'b0, {fileop_pkg::OPC_INCREMENT, 8'h22}, 8'h10);
      step(1'b1, {fileop_pkg::OPC_DEC_SKIP, 8'h22}, 8'h05);
      step(1'b1, {fileop_pkg::OPC_COMPLEMENT, 8'ha2}, 8'h00);
      step(1'b1, {fileop_pkg::OPC_JUMP, 11'h7ff}, 8'h00);
      step(1'b1, {fileop_pkg::OPC_JUMP, 11'h000}, 8'h00);
      step(1'b1, {fileop_pkg::OPC_JUMP, 11'h000}, 8'h00);
      step(1'b1, 14'h3e55, 8'h00);
      $display("test corners done");
      repeat (400)
      begin
         k = $urandom_range(0, 7);
         fdat = (k > 3) ? 8'($urandom) : ((k == 0) ? 8'h00 : ((k == 1) ? 8'h01 : 8'hff));
         if ($urandom_range(0, 6) == 0)
            step($urandom_range(0, 7) != 0, {fileop_pkg::OPC_JUMP, 11'($urandom)}, fdat);
         else
            step($urandom_range(0, 7) != 0, {ops[$urandom_range(0, 5)], 8'($urandom)},
                 fdat);
      end
      $display("test random done");
      step(1'b1, {fileop_pkg::OPC_JUMP, 11'h123}, 8'h00);
      do_reset(2);
      step(1'b0, 14'h0000, 8'h00);
      step(1'b1, {fileop_pkg::OPC_DECREMENT, 8'h01}, 8'h00);
      $display("test midreset done");
      print_verdict();
   end
endmodule
